/* File: src/basic_regs_pkg.sv */
`default_nettype none

package basic_regs_pkg;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   localparam int ADDR_WIDTH      = 21;
   localparam int INDEX_WIDTH     = 9;
   localparam int ADDR_REGION_BIT = 20;
   localparam int ADDR_MEDIA_BIT  = 12;
   localparam int DATA_WIDTH      = 8;

   // ---------------------------------------------------------------
   // Register indices
   // ---------------------------------------------------------------
   localparam logic [8:0] IDX_CHIP_ID    = 9'h000;
   localparam logic [8:0] IDX_MISC       = 9'h001;
   localparam logic [8:0] IDX_PIN_DIR    = 9'h004;
   localparam logic [8:0] IDX_PIN_LEVEL  = 9'h008;
   localparam logic [8:0] IDX_STRAP_LOW  = 9'h00c;
   localparam logic [8:0] IDX_STRAP_HIGH = 9'h00d;

   // ---------------------------------------------------------------
   // Fields and reset values
   // ---------------------------------------------------------------
   localparam int         MISC_GATE_BIT   = 7;
   localparam logic [7:0] MISC_WRITE_MASK = 8'h87;
   localparam logic [7:0] MISC_RESET      = 8'h80;
   localparam int         GPIO_COUNT      = 3;
   localparam int         GPIO_FIELD_LSB  = 1;
   localparam logic [2:0] PIN_DIR_RESET   = 3'h0;
   localparam logic [2:0] PIN_LEVEL_RESET = 3'h0;
   localparam int         STRAP_WIDTH     = 16;
   localparam int         STRAP_BANK_LSB  = 6;
   localparam int         STRAP_MEDIA_BIT = 14;
   localparam logic [1:0] BANK_ALL_GPIO   = 2'h0;
   localparam logic [1:0] BANK_FULL_ROW   = 2'h3;
   localparam logic [15:0] STRAP_RESET    = 16'h0000;

   // Function assigned to a shared pin by the straps
   typedef enum logic [2:0] {
      PIN_GENERAL = 3'b001,
      PIN_ROW_ADDR = 3'b010,
      PIN_POWER   = 3'b100
   } pin_func_e;

   // One host bus cycle as seen at the pins
   typedef struct packed {
      logic        cs_n;
      logic        mr_n;
      logic        rd_n;
      logic        wr_n;
      logic [20:0] addr;
      logic [7:0]  wdata;
   } bus_req_s;

endpackage

`default_nettype wire

/* File: src/strap_latch.sv */
`timescale 1ns/1ns
`default_nettype none

module strap_latch #(
   parameter int WIDTH = 16
) (
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_strap_config_pins,
   output logic      [WIDTH-1:0] o_strap,
   output logic                  o_ready
);

   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   if (WIDTH != basic_regs_pkg::STRAP_WIDTH) begin : g_bad_width
      $error("strap_latch width must match the strap readback registers");
   end

   // ---------------------------------------------------------------
   // Synchroniser, free running through reset
   // ---------------------------------------------------------------
   logic [WIDTH-1:0] sync_meta;
   logic [WIDTH-1:0] sync_stable;

   // No reset here so the straps are settled by the time reset lifts
   always_ff @(posedge i_clk_sys) begin
      sync_meta   <= i_strap_config_pins;
      sync_stable <= sync_meta;
   end

   // ---------------------------------------------------------------
   // Capture once at the first edge after release
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_strap <= basic_regs_pkg::STRAP_RESET;
         o_ready <= 1'b0;
      end else if (!o_ready) begin
         o_strap <= sync_stable;
         o_ready <= 1'b1;
      end
   end

endmodule

`default_nettype wire

/* File: src/shared_pin_cell.sv */
`timescale 1ns/1ns
`default_nettype none

module shared_pin_cell (
   input  wire logic i_clk_sys,
   input  wire logic i_rst_n,
   input  wire logic i_general,
   input  wire logic i_dir_out,
   input  wire logic i_level,
   input  wire logic i_alt_value,
   input  wire logic i_pin_in,
   output logic      o_pin_out,
   output logic      o_pin_oe,
   output logic      o_pin_level
);

   // ---------------------------------------------------------------
   // Pin input synchroniser
   // ---------------------------------------------------------------
   logic pin_meta;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_meta    <= 1'b0;
         o_pin_level <= 1'b0;
      end else begin
         pin_meta    <= i_pin_in;
         o_pin_level <= pin_meta;
      end
   end

   // ---------------------------------------------------------------
   // Driver select
   // ---------------------------------------------------------------
   wire next_oe  = i_general ? i_dir_out : 1'b1;
   wire next_out = i_general ? i_level : i_alt_value;

   // Registered so the pad never sees a decode glitch
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pin_oe  <= 1'b0;
         o_pin_out <= 1'b0;
      end else begin
         o_pin_oe  <= next_oe;
         o_pin_out <= next_out;
      end
   end

endmodule

`default_nettype wire

/* File: src/basic_id_gpio_strap_registers.sv */
// Behaviour
// - Identification register upper six bits: product code
// - Identification low two bits: fixed revision code
// - Reset sets gate bit; only two registers reachable
// - Writing gate bit zero opens registers and memory
// - Direction bits 3..1: one output, zero input
// - All general pins start as inputs
// - Pin three general only when bank straps 00
// - Pin one becomes row address when straps 11
// - Pin two: row address, power enable, or general
// - Non-general pin ignores its direction and level
// - Output pin drives its level register bit
// - Input pin level read returns pin state
// - Straps latched at reset release, read back
// - Select on chip, register, A20, A12 low
`timescale 1ns/1ns
`default_nettype none

module basic_id_gpio_strap_registers #(
   parameter logic [5:0] PRODUCT_CODE  = 6'h2a, // Arbitrary value
   parameter logic [1:0] REVISION_CODE = 2'h2   // Arbitrary value
) (
   input  wire logic                     i_clk_sys,
   input  wire logic                     i_rst_n,
   input  wire basic_regs_pkg::bus_req_s i_bus,
   output logic      [7:0]               o_rdata,
   output logic                          o_rd_valid,
   output logic                          o_mem_access_en,
   input  wire logic [15:0]              i_strap_config_pins,
   input  wire logic [2:0]               i_memory_row_address,
   input  wire logic                     i_media_port_power_enable,
   input  wire logic [2:0]               i_gpio_in,
   output logic      [2:0]               o_gpio_out,
   output logic      [2:0]               o_gpio_oe
);

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   wire       reg_sel   = !i_bus.cs_n && !i_bus.mr_n
                          && !i_bus.addr[basic_regs_pkg::ADDR_REGION_BIT]
                          && !i_bus.addr[basic_regs_pkg::ADDR_MEDIA_BIT];
   wire [8:0] reg_index = i_bus.addr[8:0];
   wire       wr_fire   = reg_sel && !i_bus.wr_n;
   wire       rd_fire   = reg_sel && !i_bus.rd_n;

   logic [7:0] misc;
   wire        gate_closed = misc[basic_regs_pkg::MISC_GATE_BIT];

   // Index hits; everything past the first two waits for the gate
   wire hit_id    = reg_index == basic_regs_pkg::IDX_CHIP_ID;
   wire hit_misc  = reg_index == basic_regs_pkg::IDX_MISC;
   wire hit_dir   = !gate_closed && reg_index == basic_regs_pkg::IDX_PIN_DIR;
   wire hit_level = !gate_closed && reg_index == basic_regs_pkg::IDX_PIN_LEVEL;
   wire hit_slow  = !gate_closed && reg_index == basic_regs_pkg::IDX_STRAP_LOW;
   wire hit_shigh = !gate_closed && reg_index == basic_regs_pkg::IDX_STRAP_HIGH;

   // ---------------------------------------------------------------
   // Strap capture
   // ---------------------------------------------------------------
   logic [15:0] strap;
   logic        strap_ready;

   strap_latch #(
      .WIDTH (basic_regs_pkg::STRAP_WIDTH)
   ) u_strap_latch (
      .i_clk_sys           (i_clk_sys),
      .i_rst_n             (i_rst_n),
      .i_strap_config_pins (i_strap_config_pins),
      .o_strap             (strap),
      .o_ready             (strap_ready)
   );

   // ---------------------------------------------------------------
   // Shared pin function from straps
   // ---------------------------------------------------------------
   wire [1:0] bank  = strap[basic_regs_pkg::STRAP_BANK_LSB +: 2];
   wire       media = strap[basic_regs_pkg::STRAP_MEDIA_BIT];
   wire       full_row = bank == basic_regs_pkg::BANK_FULL_ROW;

   basic_regs_pkg::pin_func_e func [3];

   // Index 0, 1, 2 are general pins 1, 2, 3
   assign func[0] = full_row ? basic_regs_pkg::PIN_ROW_ADDR
                             : basic_regs_pkg::PIN_GENERAL;
   assign func[1] = full_row ? basic_regs_pkg::PIN_ROW_ADDR
                  : media    ? basic_regs_pkg::PIN_POWER
                             : basic_regs_pkg::PIN_GENERAL;
   assign func[2] = bank == basic_regs_pkg::BANK_ALL_GPIO
                  ? basic_regs_pkg::PIN_GENERAL
                  : basic_regs_pkg::PIN_ROW_ADDR;

   // Alternate drive per pin; row bits 10, 11, 9 are index 0, 1, 2
   wire [2:0] alt_value = {i_memory_row_address[0],
                           full_row ? i_memory_row_address[2]
                                    : i_media_port_power_enable,
                           i_memory_row_address[1]};

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   logic [2:0] pin_dir;
   logic [2:0] pin_level;
   wire  [2:0] wr_field = i_bus.wdata[basic_regs_pkg::GPIO_FIELD_LSB +: 3];

   // Read-only indices have no write path at all
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         misc      <= basic_regs_pkg::MISC_RESET;
         pin_dir   <= basic_regs_pkg::PIN_DIR_RESET;
         pin_level <= basic_regs_pkg::PIN_LEVEL_RESET;
      end else if (wr_fire) begin
         if (hit_misc) begin
            misc <= i_bus.wdata & basic_regs_pkg::MISC_WRITE_MASK;
         end
         if (hit_dir) begin
            pin_dir <= wr_field;
         end
         if (hit_level) begin
            pin_level <= wr_field;
         end
      end
   end

   // ---------------------------------------------------------------
   // Shared pins
   // ---------------------------------------------------------------
   logic [2:0] pin_sync;
   wire  [2:0] general;

   for (genvar g = 0; g < basic_regs_pkg::GPIO_COUNT; g++) begin : g_pin
      assign general[g] = func[g] == basic_regs_pkg::PIN_GENERAL;

      shared_pin_cell u_cell (
         .i_clk_sys   (i_clk_sys),
         .i_rst_n     (i_rst_n),
         .i_general   (general[g]),
         .i_dir_out   (pin_dir[g]),
         .i_level     (pin_level[g]),
         .i_alt_value (alt_value[g]),
         .i_pin_in    (i_gpio_in[g]),
         .o_pin_out   (o_gpio_out[g]),
         .o_pin_oe    (o_gpio_oe[g]),
         .o_pin_level (pin_sync[g])
      );

      // General output follows its level bit one edge later
      drive_level_a: assert property (
         @(posedge i_clk_sys) disable iff (!i_rst_n)
         general[g] && pin_dir[g] |=> o_gpio_oe[g] && o_gpio_out[g] == $past(pin_level[g]))
         else $error("general output pin does not follow its level bit");

      // General input releases the pad
      input_float_a: assert property (
         @(posedge i_clk_sys) disable iff (!i_rst_n)
         general[g] && !pin_dir[g] |=> !o_gpio_oe[g])
         else $error("general input pin is being driven");

      // Strapped pin always carries its alternate function
      alt_owns_a: assert property (
         @(posedge i_clk_sys) disable iff (!i_rst_n)
         !general[g] |=> o_gpio_oe[g] && o_gpio_out[g] == $past(alt_value[g]))
         else $error("strapped pin not driven by its alternate source");
   end

   // ---------------------------------------------------------------
   // Read selection
   // ---------------------------------------------------------------
   // Input pins show the pad, outputs echo the stored level
   wire [2:0] level_view = (general & ~pin_dir & pin_sync)
                         | (~(general & ~pin_dir) & pin_level);
   wire [7:0] id_value   = {PRODUCT_CODE, REVISION_CODE};

   // Gated or unmapped indices read as zero
   wire [7:0] next_rdata = hit_id    ? id_value
                         : hit_misc  ? misc
                         : hit_dir   ? {4'h0, pin_dir, 1'b0}
                         : hit_level ? {4'h0, level_view, 1'b0}
                         : hit_slow  ? strap[7:0]
                         : hit_shigh ? strap[15:8]
                         : 8'h00;

   // One-edge read latency; data holds until the next read
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata         <= 8'h00;
         o_rd_valid      <= 1'b0;
         o_mem_access_en <= 1'b0;
      end else begin
         o_rd_valid      <= rd_fire;
         o_mem_access_en <= !gate_closed;
         if (rd_fire) begin
            o_rdata <= next_rdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence read_of_index(logic [8:0] idx);
      rd_fire && reg_index == idx;
   endsequence

   sequence gate_open_write;
      wr_fire && hit_misc && !i_bus.wdata[basic_regs_pkg::MISC_GATE_BIT];
   endsequence

   id_value_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      read_of_index(basic_regs_pkg::IDX_CHIP_ID)
      |=> o_rd_valid && o_rdata == {PRODUCT_CODE, REVISION_CODE})
      else $error("identification read returned a wrong value");

   reset_state_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(strap_ready) |-> gate_closed && pin_dir == 3'h0 && !o_mem_access_en)
      else $error("control state wrong after reset release");

   gate_blocks_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (read_of_index(basic_regs_pkg::IDX_STRAP_LOW) and gate_closed)
      |=> o_rd_valid && o_rdata == 8'h00)
      else $error("gated register visible before the gate opened");

   gate_open_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      gate_open_write |=> !gate_closed ##1 o_mem_access_en)
      else $error("memory access not opened after gate write");

   strap_route_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      strap_ready |-> general[2] == (bank == 2'h0) && general[0] == (bank != 2'h3)
                      && general[1] == (bank != 2'h3 && !media))
      else $error("shared pin function disagrees with straps");

   strap_read_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (read_of_index(basic_regs_pkg::IDX_STRAP_HIGH) and !gate_closed)
      |=> o_rdata == $past(strap[15:8]))
      else $error("strap readback high byte wrong");

   input_read_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (read_of_index(basic_regs_pkg::IDX_PIN_LEVEL)
       and (!gate_closed && general[0] && !pin_dir[0]))
      |=> o_rdata[1] == $past(pin_sync[0]))
      else $error("input pin level read does not show the pad");

   unselected_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      !reg_sel |=> !o_rd_valid)
      else $error("read answered without register select");

   ro_write_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      wr_fire && (hit_id || hit_slow || hit_shigh)
      |=> $stable(misc) && $stable(pin_dir) && $stable(pin_level) && $stable(strap))
      else $error("write to read-only register changed state");

   // Reads answer on the very next edge
   read_answer_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      rd_fire |=> o_rd_valid)
      else $error("taken read not answered one edge later");

   // Low strap byte comes back bit for bit once the gate is open
   strap_low_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (read_of_index(basic_regs_pkg::IDX_STRAP_LOW) and !gate_closed)
      |=> o_rdata == $past(strap[7:0]))
      else $error("strap readback low byte wrong");

   // Direction write lands on the next edge
   dir_write_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      wr_fire && hit_dir |=> pin_dir == $past(wr_field))
      else $error("direction register did not take the written field");

   // Level write lands on the next edge
   level_write_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      wr_fire && hit_level |=> pin_level == $past(wr_field))
      else $error("level register did not take the written field");

   // A closed gate keeps the pin registers out of reach
   gated_write_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      wr_fire && gate_closed && !hit_id && !hit_misc
      |=> $stable(pin_dir) && $stable(pin_level))
      else $error("pin register written while the gate was closed");

   // Misc write keeps only the stored bits
   misc_write_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      wr_fire && hit_misc |=> misc == ($past(i_bus.wdata) & basic_regs_pkg::MISC_WRITE_MASK))
      else $error("misc register did not take the written value");

   // Setting the gate again shuts memory one edge later
   gate_close_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      wr_fire && hit_misc && i_bus.wdata[basic_regs_pkg::MISC_GATE_BIT]
      |=> gate_closed ##1 !o_mem_access_en)
      else $error("memory access still open after gate set");

endmodule

`default_nettype wire

/* File: tb/host_bus_model.sv */
`timescale 1ns/1ns
`default_nettype none

// Host processor on the register bus: one access per call, driven on falling edges
module host_bus_model (
   input  wire logic               i_clk_sys,
   input  wire logic               i_rd_valid,
   input  wire logic [7:0]         i_rdata,
   output var basic_regs_pkg::bus_req_s o_bus
);
   initial o_bus = {4'hf, 21'h000000, 8'h00};

   // Release: strobes high, address and data flip so stale values never match
   task automatic idle();
      o_bus.cs_n = 1'b1;
      o_bus.mr_n = 1'b1;
      o_bus.rd_n = 1'b1;
      o_bus.wr_n = 1'b1;
      o_bus.addr = ~o_bus.addr;
      o_bus.wdata = ~o_bus.wdata;
   endtask

   task automatic start(input logic [20:0] a);
      @(negedge i_clk_sys);
      o_bus.cs_n = 1'b0;
      o_bus.mr_n = 1'b0;
      o_bus.addr = a;
   endtask

   // Misc bits other than the gate bit always go out as zero
   task automatic wr(input logic [20:0] a, input logic [7:0] d);
      start(a);
      o_bus.wdata = (a[8:0] == basic_regs_pkg::IDX_MISC) ? (d & 8'h80) : d;
      o_bus.wr_n = 1'b0;
      @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      idle();
   endtask

   // Taken at one rising edge; the answer is waited for a bounded time
   task automatic rd(input logic [20:0] a, output logic [7:0] d, output logic ok);
      start(a);
      o_bus.rd_n = 1'b0;
      @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      idle();
      ok = 1'b0;
      d = 8'h00;
      for (int k = 0; k < 3 && !ok; k++) begin
         if (i_rd_valid === 1'b1) begin
            ok = 1'b1;
            d = i_rdata;
         end else begin
            @(negedge i_clk_sys);
         end
      end
   endtask
endmodule

`default_nettype wire

/* File: tb/basic_id_gpio_strap_registers_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module basic_id_gpio_strap_registers_tb_top;
   logic                     i_clk_sys;
   logic                     i_rst_n;
   basic_regs_pkg::bus_req_s bus;
   logic [7:0]               rdata;
   logic                     rd_valid;
   logic                     mem_en;
   logic [15:0]              strap;
   logic [2:0]               row;
   logic                     pwr;
   logic [2:0]               gin;
   logic [2:0]               gout;
   logic [2:0]               goe;
   logic [7:0]               d;
   logic                     ok;
   int                       n_fail;
   int                       samples_checked;
   logic [15:0]              straps [5] = '{16'h1224, 16'h5a03, 16'h3f7c, 16'h4081, 16'hc3c5};

   basic_id_gpio_strap_registers dut_u (
      .i_clk_sys                 (i_clk_sys),
      .i_rst_n                   (i_rst_n),
      .i_bus                     (bus),
      .o_rdata                   (rdata),
      .o_rd_valid                (rd_valid),
      .o_mem_access_en           (mem_en),
      .i_strap_config_pins       (strap),
      .i_memory_row_address      (row),
      .i_media_port_power_enable (pwr),
      .i_gpio_in                 (gin),
      .o_gpio_out                (gout),
      .o_gpio_oe                 (goe)
   );

   host_bus_model host_u (
      .i_clk_sys  (i_clk_sys),
      .i_rd_valid (rd_valid),
      .i_rdata    (rdata),
      .o_bus      (bus)
   );

   // ---------------------------------------------------------------
   // Checking helpers
   // ---------------------------------------------------------------
   task automatic complete_run();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic cmp(input string name, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask

   // A read with no answer in time ends the run
   task automatic rdc(input logic [20:0] a, input logic [7:0] e, input string name);
      host_u.rd(a, d, ok);
      if (ok !== 1'b1) begin
         n_fail++;
         $display("ERROR %s expected answer seen none", name);
         complete_run();
      end else begin
         cmp(name, e, d);
      end
   endtask

   // Pins left general by the straps: index 0..2 is pin 1..3
   function automatic logic [2:0] gen_f(input logic [15:0] s);
      return {s[7:6] == 2'h0, s[7:6] != 2'h3 && !s[14], s[7:6] != 2'h3};
   endfunction

   // Expected pads after sync delay; out only matters where driven
   task automatic pins(input logic [2:0] dir, input logic [2:0] lvl);
      logic [2:0] g;
      logic [2:0] alt;
      logic [2:0] eoe;
      g = gen_f(strap);
      alt = {row[0], (strap[7:6] == 2'h3) ? row[2] : pwr, row[1]};
      eoe = (g & dir) | ~g;
      repeat (3) @(negedge i_clk_sys);
      cmp("pin_oe", {5'h00, eoe}, {5'h00, goe});
      cmp("pin_out", {5'h00, ((g & lvl) | (~g & alt)) & eoe}, {5'h00, gout & goe});
   endtask

   task automatic reset_dut(input logic [15:0] s);
      @(negedge i_clk_sys);
      i_rst_n = 1'b0;
      strap = s;
      repeat (2) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      i_rst_n = 1'b1;
      repeat (2) @(negedge i_clk_sys);
   endtask

   // ---------------------------------------------------------------
   // Clock and main sequence
   // ---------------------------------------------------------------
   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end

   // Every strap combination class gets its own reset and full pass
   initial begin
      i_rst_n = 1'b0;
      strap = 16'h0000;
      row = 3'h5;
      pwr = 1'b1;
      gin = 3'h0;
      n_fail = 0;
      samples_checked = 0;
      foreach (straps[k]) begin
         reset_dut(straps[k]);
         cmp("mem_en_reset", 8'h00, {7'h00, mem_en});
         rdc(21'h000000, {6'h2a, 2'h2}, "chip_id");
         host_u.wr(21'h000000, 8'hff);
         rdc(21'h000000, {6'h2a, 2'h2}, "chip_id_wr");
         host_u.wr(21'h000004, 8'h0e);
         rdc(21'h00000c, 8'h00, "gated_read");
         rdc(21'h000001, 8'h80, "misc_reset");
         host_u.wr(21'h000001, 8'h00);
         repeat (2) @(negedge i_clk_sys);
         cmp("mem_en_open", 8'h01, {7'h00, mem_en});
         rdc(21'h000004, 8'h00, "dir_reset");
         rdc(21'h00000c, strap[7:0], "strap_low");
         rdc(21'h000e0d, strap[15:8], "strap_high");
         host_u.wr(21'h00000d, 8'h00);
         rdc(21'h00000d, strap[15:8], "strap_wr");
         host_u.rd(21'h00100c, d, ok);
         cmp("a12_unselected", 8'h00, {7'h00, ok});
         host_u.rd(21'h10000c, d, ok);
         cmp("a20_unselected", 8'h00, {7'h00, ok});
         pins(3'h0, 3'h0);
         host_u.wr(21'h000004, 8'h0e);
         host_u.wr(21'h000008, 8'h0a);
         pins(3'h7, 3'h5);
         row = 3'h2;
         pwr = 1'b0;
         pins(3'h7, 3'h5);
         rdc(21'h000008, 8'h0a, "level_out");
         host_u.wr(21'h000008, 8'h04);
         pins(3'h7, 3'h2);
         host_u.wr(21'h000004, 8'h00);
         gin = 3'h5;
         pins(3'h0, 3'h2);
         rdc(21'h000008, {4'h0, (gen_f(strap) & gin) | (~gen_f(strap) & 3'h2), 1'b0},
             "level_in");
         host_u.wr(21'h000001, 8'h80);
         rdc(21'h00000d, 8'h00, "regated_read");
         cmp("mem_en_closed", 8'h00, {7'h00, mem_en});
         row = 3'h5;
         pwr = 1'b1;
         gin = 3'h0;
      end
      complete_run();
   end
endmodule

`default_nettype wire
